/* logic/mim_pkg.sv */
// constants and types for the motion interrupt mapper
package mim_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NSRC   = 4;
  localparam int unsigned NPIN   = 2;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_ROUTE_A = 12'h004;
  localparam logic [11:0] OFS_ROUTE_B = 12'h008;
  localparam logic [11:0] OFS_STATUS  = 12'h00C;

  // source bit positions, shared by route and status layouts
  localparam int unsigned SRC_DRDY  = 0;
  localparam int unsigned SRC_ACT   = 1;
  localparam int unsigned SRC_INACT = 2;
  localparam int unsigned SRC_AWAKE = 3;

  // route register fields
  localparam int unsigned ROUTE_POL = 7;
  localparam int unsigned ROUTE_W   = 8;

  // ctrl register fields
  localparam int unsigned CTRL_MODE_LO = 0;
  localparam int unsigned CTRL_MODE_W  = 2;

  // reset values
  localparam logic [7:0] ROUTE_RST = 8'h00;
  localparam logic [1:0] MODE_RST  = 2'h0;

  typedef enum logic [1:0] {
    MIM_DEFAULT = 2'b00,
    MIM_LINKED  = 2'b01,
    MIM_LOOP    = 2'b10
  } mim_mode_t;

  typedef struct packed {
    logic [1:0]                  mode;
    logic [NPIN-1:0][ROUTE_W-1:0] route;
    logic                        act_lat;
    logic                        inact_lat;
    logic                        awake;
    logic [NPIN-1:0]             pin_lvl;
    logic [NPIN-1:0]             pin_oe_n;
    logic [DATA_W-1:0]           prdata;
    logic                        pslverr;
  } mim_state_t;

endpackage : mim_pkg

/* logic/mim_mapper.sv */
// motion interrupt mapper: awake flag, event latches, pin routing, apb registers
`timescale 1ns/1ns

// Overview of operation
// - activity sets awake, inactivity clears it
// - awake flag routable to either pin
// - per-source enable bits in both route registers
// - all sources work concurrently
// - pin asserted is OR of routed sources
// - no source routed means pin high-Z
// - reset puts both pins high-Z
// - pin asserted while routed source asserted
// - default polarity active high
// - polarity bit makes pin active low
// - status register shows each source
// - inactivity event serves free-fall detection
// - default/linked events latch until status read
// - loop mode alternates and re-arms itself
module mim_mapper
  import mim_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              data_ready,
  input  wire logic              act_evt,
  input  wire logic              inact_evt,
  output logic                   act_arm,
  output logic                   inact_arm,
  output logic                   irq_pin_a_o,
  output logic                   irq_pin_a_oe_n,
  output logic                   irq_pin_b_o,
  output logic                   irq_pin_b_oe_n
);

  mim_state_t s;
  mim_state_t next_s;

  logic            setup_ph;
  logic            access_ph;
  logic            rd_status;
  logic            act_take;
  logic            inact_take;
  logic [NSRC-1:0] src;
  logic [NPIN-1:0] want_lvl;
  logic [NPIN-1:0] want_oe_n;
  mim_mode_t       mode;

  assign mode      = mim_mode_t'(s.mode);
  assign setup_ph  = psel && !penable;
  assign access_ph = psel && penable;
  // zero wait states keeps the host's isr short
  assign pready    = 1'b1;
  assign rd_status = access_ph && !pwrite && (paddr == OFS_STATUS);

  // detector arming: linked waits for the host, loop does not
  always_comb begin
    unique case (mode)
      MIM_LINKED: begin
        act_arm   = !s.awake && !s.act_lat && !s.inact_lat;
        inact_arm = s.awake && !s.act_lat && !s.inact_lat;
      end
      MIM_LOOP: begin
        act_arm   = !s.awake;
        inact_arm = s.awake;
      end
      default: begin
        act_arm   = !s.act_lat;
        inact_arm = !s.inact_lat;
      end
    endcase
  end

  assign act_take   = act_evt && act_arm;
  // inactivity from the detector includes the all-axes-low free-fall case
  assign inact_take = inact_evt && inact_arm;

  always_comb begin
    src            = '0;
    src[SRC_DRDY]  = data_ready;
    src[SRC_ACT]   = s.act_lat;
    src[SRC_INACT] = s.inact_lat;
    src[SRC_AWAKE] = s.awake;
  end

  // pin logic: enable from route alone, polarity after the OR
  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      want_oe_n[p] = ~|s.route[p][NSRC-1:0];
      want_lvl[p]  = (|(s.route[p][NSRC-1:0] & src)) ^ s.route[p][ROUTE_POL];
    end
  end

  always_comb begin
    next_s          = s;
    next_s.pin_lvl  = want_lvl;
    next_s.pin_oe_n = want_oe_n;

    // awake tracks the last accepted motion event; activity wins a tie
    if (act_take) begin
      next_s.awake = 1'b1;
    end else if (inact_take) begin
      next_s.awake = 1'b0;
    end

    // read clears the latches, a same-cycle event still sets them
    if (rd_status) begin
      next_s.act_lat   = 1'b0;
      next_s.inact_lat = 1'b0;
    end
    if (mode == MIM_LOOP) begin
      if (act_take) begin
        next_s.inact_lat = 1'b0;
      end
      if (inact_take) begin
        next_s.act_lat = 1'b0;
      end
    end
    if (act_take) begin
      next_s.act_lat = 1'b1;
    end
    if (inact_take) begin
      next_s.inact_lat = 1'b1;
    end

    // read data and error are prepared in the setup cycle
    if (setup_ph) begin
      next_s.prdata  = '0;
      next_s.pslverr = 1'b0;
      unique case (paddr)
        OFS_CTRL: begin
          next_s.prdata[CTRL_MODE_LO +: CTRL_MODE_W] = s.mode;
        end
        OFS_ROUTE_A: begin
          next_s.prdata[ROUTE_W-1:0] = s.route[0];
        end
        OFS_ROUTE_B: begin
          next_s.prdata[ROUTE_W-1:0] = s.route[1];
        end
        OFS_STATUS: begin
          next_s.prdata[NSRC-1:0] = src;
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end

    if (access_ph && pwrite) begin
      unique case (paddr)
        OFS_CTRL: begin
          next_s.mode = pwdata[CTRL_MODE_LO +: CTRL_MODE_W];
        end
        OFS_ROUTE_A: begin
          next_s.route[0] = pwdata[ROUTE_W-1:0];
        end
        OFS_ROUTE_B: begin
          next_s.route[1] = pwdata[ROUTE_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s.mode      <= MODE_RST;
      s.route     <= {NPIN{ROUTE_RST}};
      s.act_lat   <= 1'b0;
      s.inact_lat <= 1'b0;
      s.awake     <= 1'b0;
      s.pin_lvl   <= '0;
      s.pin_oe_n  <= '1;
      s.prdata    <= '0;
      s.pslverr   <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata         = s.prdata;
  assign pslverr        = s.pslverr;
  assign irq_pin_a_o    = s.pin_lvl[0];
  assign irq_pin_a_oe_n = s.pin_oe_n[0];
  assign irq_pin_b_o    = s.pin_lvl[1];
  assign irq_pin_b_oe_n = s.pin_oe_n[1];

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_awake_set;
    act_take |=> s.awake;
  endproperty
  a_awake_set: assert property (p_awake_set) else $error("awake not set");

  property p_awake_clr;
    inact_take && !act_take |=> !s.awake ##1 (s.awake || !irq_pin_a_o || !s.route[0][SRC_AWAKE]
      || s.route[0][ROUTE_POL] || (|s.route[0][2:0]));
  endproperty
  a_awake_clr: assert property (p_awake_clr) else $error("awake not cleared");

  property p_hiz;
    (s.route[1][NSRC-1:0] == '0) |=> irq_pin_b_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pin b driven with no source");

  property p_rst_hiz;
    @(posedge pclk) disable iff (1'b0) !presetn |-> irq_pin_a_oe_n && irq_pin_b_oe_n;
  endproperty
  a_rst_hiz: assert property (p_rst_hiz) else $error("pin driven in reset");

  property p_or_high;
    !s.route[0][ROUTE_POL] && (|(s.route[0][NSRC-1:0] & src)) |=> irq_pin_a_o && !irq_pin_a_oe_n;
  endproperty
  a_or_high: assert property (p_or_high) else $error("pin a not asserted");

  property p_pol_low;
    s.route[1][ROUTE_POL] && (|(s.route[1][NSRC-1:0] & src)) |=> !irq_pin_b_o;
  endproperty
  a_pol_low: assert property (p_pol_low) else $error("pin b not active low");

  property p_latch_hold;
    s.act_lat && mode != MIM_LOOP && !rd_status |=> s.act_lat;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch lost");

  property p_read_clear;
    rd_status && !act_take |=> !s.act_lat;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear");

  property p_loop_arm;
    mode == MIM_LOOP |-> (act_arm == !s.awake) && (inact_arm == s.awake);
  endproperty
  a_loop_arm: assert property (p_loop_arm) else $error("loop arming wrong");

  property p_status_rd;
    setup_ph && !pwrite && paddr == OFS_STATUS |=> prdata[NSRC-1:0] == $past(src);
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("status read wrong");

  property p_reg_pin;
    ##1 irq_pin_a_o == $past(want_lvl[0]) && irq_pin_b_oe_n == $past(want_oe_n[1]);
  endproperty
  a_reg_pin: assert property (p_reg_pin) else $error("pin not registered");

  property p_awake_hold;
    !act_take && !inact_take |=> s.awake == $past(s.awake);
  endproperty
  a_awake_hold: assert property (p_awake_hold) else $error("awake changed");

  property p_hiz_a;
    (s.route[0][NSRC-1:0] == '0) |=> irq_pin_a_oe_n;
  endproperty
  a_hiz_a: assert property (p_hiz_a) else $error("pin a driven with no source");

  property p_drive_a;
    (s.route[0][NSRC-1:0] != '0) |=> !irq_pin_a_oe_n;
  endproperty
  a_drive_a: assert property (p_drive_a) else $error("pin a not driven");

  property p_drive_b;
    (s.route[1][NSRC-1:0] != '0) |=> !irq_pin_b_oe_n;
  endproperty
  a_drive_b: assert property (p_drive_b) else $error("pin b not driven");

  property p_or_high_b;
    !s.route[1][ROUTE_POL] && (|(s.route[1][NSRC-1:0] & src)) |=> irq_pin_b_o;
  endproperty
  a_or_high_b: assert property (p_or_high_b) else $error("pin b not asserted");

  property p_idle_low_a;
    !s.route[0][ROUTE_POL] && !(|(s.route[0][NSRC-1:0] & src)) |=> !irq_pin_a_o;
  endproperty
  a_idle_low_a: assert property (p_idle_low_a) else $error("pin a high when idle");

  property p_pol_idle_b;
    s.route[1][ROUTE_POL] && !(|(s.route[1][NSRC-1:0] & src)) |=> irq_pin_b_o;
  endproperty
  a_pol_idle_b: assert property (p_pol_idle_b) else $error("pin b low when idle");

  property p_inact_hold;
    s.inact_lat && mode != MIM_LOOP && !rd_status |=> s.inact_lat;
  endproperty
  a_inact_hold: assert property (p_inact_hold) else $error("inact latch lost");

  property p_read_clear_i;
    rd_status && !inact_take |=> !s.inact_lat;
  endproperty
  a_read_clear_i: assert property (p_read_clear_i) else $error("inact not cleared");

  property p_linked_wait;
    mode == MIM_LINKED && (s.act_lat || s.inact_lat) |-> !act_arm && !inact_arm;
  endproperty
  a_linked_wait: assert property (p_linked_wait) else $error("linked armed early");

  property p_default_arm;
    mode == MIM_DEFAULT && !s.act_lat && !s.inact_lat |-> act_arm && inact_arm;
  endproperty
  a_default_arm: assert property (p_default_arm) else $error("default not armed");

  property p_loop_clear;
    mode == MIM_LOOP && act_take && !inact_take |=> !s.inact_lat;
  endproperty
  a_loop_clear: assert property (p_loop_clear) else $error("loop latch kept");

  property p_act_latch;
    act_take |=> s.act_lat;
  endproperty
  a_act_latch: assert property (p_act_latch) else $error("act not latched");

  property p_inact_latch;
    inact_take |=> s.inact_lat;
  endproperty
  a_inact_latch: assert property (p_inact_latch) else $error("inact not latched");

  property p_route_wr;
    access_ph && pwrite && paddr == OFS_ROUTE_A |=> s.route[0] == $past(pwdata[ROUTE_W-1:0]);
  endproperty
  a_route_wr: assert property (p_route_wr) else $error("route a write lost");

  property p_mode_wr;
    access_ph && pwrite && paddr == OFS_CTRL |=> s.mode == $past(pwdata[CTRL_MODE_W-1:0]);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

  c_wake: cover property (act_take ##[1:20] inact_take);
  c_loop: cover property (mode == MIM_LOOP && act_take);
  c_both: cover property (!irq_pin_a_oe_n && !irq_pin_b_oe_n);
  c_rdclr: cover property (rd_status && s.inact_lat);

endmodule : mim_mapper

/* tb/mim_host_model.sv */
// host interrupt inputs with pull-downs, fed by the two mapper pins
`timescale 1ns/1ns
module mim_host_model (
  input  wire logic pin_a,
  input  wire logic oe_n_a,
  input  wire logic pin_b,
  input  wire logic oe_n_b,
  output logic      irq_a,
  output logic      irq_b
);
  // a released pin settles to the pull-down level, never the last value
  assign irq_a = oe_n_a ? 1'h0 : pin_a;
  assign irq_b = oe_n_b ? 1'h0 : pin_b;
endmodule : mim_host_model

/* tb/mim_mapper_tb_top.sv */
// self-checking bench for the motion interrupt mapper
`timescale 1ns/1ns
module mim_mapper_tb_top;
  import mim_pkg::*;
  logic              pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
  logic              data_ready = 0, act_evt = 0, inact_evt = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic              pready, pslverr, act_arm, inact_arm, err, d;
  logic              pa, pa_oe_n, pb, pb_oe_n, ha, hb;
  int                mismatches = 0, samples_checked = 0;

  always #5 pclk = ~pclk;

  mim_mapper DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .data_ready(data_ready), .act_evt(act_evt), .inact_evt(inact_evt),
    .act_arm(act_arm), .inact_arm(inact_arm), .irq_pin_a_o(pa), .irq_pin_a_oe_n(pa_oe_n),
    .irq_pin_b_o(pb), .irq_pin_b_oe_n(pb_oe_n));
  mim_host_model host (.pin_a(pa), .oe_n_a(pa_oe_n), .pin_b(pb), .oe_n_b(pb_oe_n),
    .irq_a(ha), .irq_b(hb));

  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // request held from setup until the edge that samples pready high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // pins are one register stage behind their cause
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task pulse(input logic act);
    @(posedge pclk);
    if (act) act_evt <= 1; else inact_evt <= 1;
    @(posedge pclk);
    act_evt <= 0;
    inact_evt <= 0;
    settle();
  endtask : pulse

  initial begin
    // a real falling edge, so the asynchronous reset branch surely runs
    presetn <= 1'b0;
    void'($urandom(32'h09AC));
    repeat (6) @(posedge pclk);
    chk("pins in reset", {pa_oe_n, pb_oe_n, ha, hb}, 4'hC);
    presetn <= 1;
    apb(0, OFS_STATUS, 0);
    chk("status", rd, 32'h0);
    apb(0, OFS_ROUTE_A, 0);
    chk("route a", rd, {24'h0, ROUTE_RST});
    apb(1, OFS_ROUTE_A, 32'h01);
    apb(1, OFS_ROUTE_B, 32'h81);
    apb(0, OFS_ROUTE_B, 0);
    chk("route b", rd, 32'h81);
    repeat (8) begin
      @(posedge pclk);
      d = 1'($urandom);
      data_ready <= d;
      settle();
      chk("pins", {pa_oe_n, pa, pb_oe_n, pb}, {1'h0, d, 1'h0, ~d});
    end
    apb(1, OFS_ROUTE_B, 32'h80);
    settle();
    chk("pin b off", {pb_oe_n, hb}, 2'h2);
    @(posedge pclk);
    data_ready <= 0;
    apb(1, OFS_ROUTE_A, 32'h08);
    apb(1, OFS_ROUTE_B, 32'h07);
    pulse(1);
    chk("awake", {pa, pb, act_arm}, 3'h6);
    apb(0, OFS_STATUS, 0);
    chk("status act", rd, 32'h0A);
    apb(0, OFS_STATUS, 0);
    chk("status read", rd, 32'h08);
    settle();
    chk("act rearm", act_arm, 1'h1);
    pulse(0);
    chk("asleep", {pa, inact_arm}, 2'h0);
    apb(0, OFS_STATUS, 0);
    chk("status inact", rd, 32'h04);
    apb(1, OFS_CTRL, 32'h01);
    pulse(1);
    chk("linked wait", {pa, inact_arm}, 2'h2);
    apb(0, OFS_STATUS, 0);
    settle();
    chk("linked arm", {rd[3:0], inact_arm, act_arm}, 6'h2A);
    apb(1, OFS_CTRL, 32'h02);
    pulse(0);
    pulse(1);
    chk("loop", {pa, act_arm, inact_arm}, 3'h5);
    apb(1, OFS_CTRL, 32'h03);
    apb(0, OFS_CTRL, 0);
    chk("mode read", rd, 32'h03);
    pulse(0);
    chk("mode 3 default", {pa, act_arm, inact_arm}, 3'h0);
    apb(0, 12'h010, 0);
    chk("unmapped err", err, 1'h1);
    chk("unmapped data", rd, 32'h0);
    conclude();
  end
endmodule : mim_mapper_tb_top
